/* hdl/boot_strap_config_capture.v */
// Boot strap capture, applied configuration and expansion data lane control.
`include "boot_strap_config_defines.vh"

// Function
// RULE_01 - Drive strength follows the two drive strap bits: 01 medium, 10 low, 11 high, 00 reserved.
// RULE_02 - The high drive strength bit is taken from address strap bit 9.
// RULE_03 - The PCI clock select strap picks 33 MHz when 0 and 66 MHz when 1.
// RULE_04 - The board must not pull reserved address strap bit 3 low during capture.
// RULE_05 - The PCI arbiter is enabled when its strap bit is 1 and disabled when 0.
// RULE_06 - The PCI controller acts as host when its strap bit is 1 and as non-host when 0.
// RULE_07 - Strap bits 7 and 0 give the boot flash width: 00 16-bit, 01 8-bit, 11 32-bit, 10 reserved.
// RULE_08 - In 8-bit accesses data lines 31 to 8 are driven with filler on writes and released on reads.
// RULE_09 - In 16-bit accesses data lines 31 to 16 are driven with filler on writes and released on reads.
// RULE_10 - Configuration bits 0 and 7 read as one during reset unless their strap pin is pulled low; here they read one in reset whatever the pins.
// RULE_11 - The board straps the address pins during reset to choose the boot flash width.
// RULE_12 - After boot software may override the strapped access width through a control register.
// RULE_13 - Strap levels are latched at reset release and held stable until the next reset.
module boot_strap_config_capture #(
  parameter DATA_WIDTH = 32 // Expansion data bus width.
) (
  input wire clk, // System clock, 20 MHz.
  input wire reset_n, // Asynchronous reset, active low.
  input wire [`STRAP_WIDTH-1:0] expansionAddressPins, // Expansion address pins read as straps.
  input wire [DATA_WIDTH-1:0] coreWriteData, // Write data from the bus controller.
  input wire [DATA_WIDTH-1:0] expansionDataPinsIn, // Level on the expansion data pins.
  input wire accessActive, // Bus controller has an access in progress.
  input wire accessWrite, // The access in progress is a write.
  input wire [3:0] wb_adr_i, // Wishbone byte address.
  input wire [31:0] wb_dat_i, // Wishbone write data.
  input wire [3:0] wb_sel_i, // Wishbone byte selects.
  input wire wb_we_i, // Wishbone write enable.
  input wire wb_cyc_i, // Wishbone cycle.
  input wire wb_stb_i, // Wishbone strobe.
  output reg [31:0] wb_dat_o, // Wishbone read data.
  output reg wb_ack_o, // Wishbone acknowledge.
  output reg [DATA_WIDTH-1:0] expansionDataPinsOut, // Data driven onto the pins.
  output reg [DATA_WIDTH-1:0] expansionDataPinsOe_n, // Per-line enable, low drives.
  output reg [DATA_WIDTH-1:0] readData, // Captured read data with unused lanes zero.
  output reg [1:0] busDriveStrength, // Applied drive strength code.
  output reg pciClockIs66, // PCI clock select, high for 66 MHz.
  output reg hostBusArbiterEnable, // PCI arbiter enable.
  output reg pciHostRole, // PCI controller is bus host.
  output reg [1:0] flashWidth, // Active chip select 0 data width.
  output reg strapsValid // Straps have been captured.
);

  // Straps pass two flops since the pins are not on this clock.
  reg [`STRAP_WIDTH-1:0] strapSync1_reg;
  reg [`STRAP_WIDTH-1:0] strapSync2_reg;
  reg [`STRAP_WIDTH-1:0] config_reg;
  reg captured_reg;
  reg [2:0] widthCtrl_reg;
  reg [DATA_WIDTH-1:0] dataSync1_reg;
  reg [DATA_WIDTH-1:0] dataSync2_reg;

  wire [1:0] strapWidth;
  wire [1:0] strapDrive;
  wire [1:0] activeWidth;
  wire busHit;
  wire [DATA_WIDTH-1:0] usedMask;

  // Lanes in use for a given width code; reserved codes are treated as full width.
  function [DATA_WIDTH-1:0] laneMask;
    input [1:0] width;
    begin
      case (width)
        `WIDTH_8: laneMask = {{(DATA_WIDTH-8){1'b0}}, 8'hFF}; // RULE_08
        `WIDTH_16: laneMask = {{(DATA_WIDTH-16){1'b0}}, 16'hFFFF}; // RULE_09
        default: laneMask = {DATA_WIDTH{1'b1}};
      endcase
    end
  endfunction

  assign strapWidth = {config_reg[`BIT_WIDTH_HIGH], config_reg[`BIT_WIDTH_LOW]}; // RULE_07
  assign strapDrive = {config_reg[`BIT_DRIVE_HIGH], config_reg[`BIT_DRIVE_LOW]}; // RULE_02
  assign activeWidth = widthCtrl_reg[`WOVR_ENABLE_BIT] ? widthCtrl_reg[1:0] : strapWidth; // RULE_12
  assign usedMask = laneMask(activeWidth);
  assign busHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Synchronisers; the first stage is only read by the second.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapSync1_reg <= `STRAP_DEFAULT;
      strapSync2_reg <= `STRAP_DEFAULT;
      dataSync1_reg <= {DATA_WIDTH{1'b0}};
      dataSync2_reg <= {DATA_WIDTH{1'b0}};
    end else begin
      strapSync1_reg <= expansionAddressPins;
      strapSync2_reg <= strapSync1_reg;
      dataSync1_reg <= expansionDataPinsIn;
      dataSync2_reg <= dataSync1_reg;
    end
  end

  // During reset the configuration shows the pulled-up default, so bits 0 and 7 read as one.
  // The capture is taken once, from the synchronised pins, on the third edge after release.
  // That delay lets the strap levels settle through the synchronisers first.
  reg [1:0] settle_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= `STRAP_DEFAULT; // RULE_10
      captured_reg <= 1'b0;
      settle_reg <= 2'h0;
    end else if (!captured_reg) begin
      if (settle_reg == 2'h2) begin
        config_reg <= strapSync2_reg; // RULE_13
        captured_reg <= 1'b1; // RULE_13
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // Wishbone slave: one ack a cycle after the strobe, released the cycle after.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      widthCtrl_reg <= 3'h0;
    end else begin
      wb_ack_o <= busHit;
      wb_dat_o <= 32'h00000000;
      if (busHit && wb_we_i && wb_adr_i == `ADDR_WIDTH_CTRL && wb_sel_i[0]) begin
        widthCtrl_reg <= wb_dat_i[2:0]; // RULE_12
      end
      if (busHit && !wb_we_i) begin
        case (wb_adr_i)
          `ADDR_CONFIG: wb_dat_o <= {{(32-`STRAP_WIDTH){1'b0}}, config_reg};
          `ADDR_WIDTH_CTRL: wb_dat_o <= {29'h0, widthCtrl_reg};
          `ADDR_DATA_LANE: wb_dat_o <= {26'h0, captured_reg, activeWidth, strapDrive, 1'b0};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Applied configuration; until capture the reset defaults stand.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busDriveStrength <= `DRIVE_HIGH;
      pciClockIs66 <= 1'b1;
      hostBusArbiterEnable <= 1'b1;
      pciHostRole <= 1'b1;
      flashWidth <= `WIDTH_32;
      strapsValid <= 1'b0;
    end else begin
      busDriveStrength <= strapDrive; // RULE_01
      pciClockIs66 <= config_reg[`BIT_PCI_CLOCK]; // RULE_03
      hostBusArbiterEnable <= config_reg[`BIT_ARB_ENABLE]; // RULE_05
      pciHostRole <= config_reg[`BIT_HOST_ROLE]; // RULE_06
      flashWidth <= activeWidth; // RULE_07
      strapsValid <= captured_reg;
    end
  end

  // Data lanes: used lanes follow the access; unused lanes carry filler on writes and are
  // released on reads, so a narrow device never sees contention on the upper lanes.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      expansionDataPinsOut <= {DATA_WIDTH{1'b0}};
      expansionDataPinsOe_n <= {DATA_WIDTH{1'b1}};
      readData <= {DATA_WIDTH{1'b0}};
    end else begin
      expansionDataPinsOut <= (coreWriteData & usedMask)
        | (`FILLER_PATTERN & ~usedMask); // RULE_08 RULE_09
      expansionDataPinsOe_n <= (accessActive && accessWrite) ? {DATA_WIDTH{1'b0}}
        : {DATA_WIDTH{1'b1}}; // RULE_08 RULE_09
      readData <= dataSync2_reg & usedMask;
    end
  end

endmodule

/* hdl/boot_strap_config_defines.vh */
// Register offsets, field positions, reset values and encodings of the strap capture block.
`ifndef BOOT_STRAP_CONFIG_DEFINES_VH
`define BOOT_STRAP_CONFIG_DEFINES_VH

`define ADDR_CONFIG 4'h0
`define ADDR_WIDTH_CTRL 4'h4
`define ADDR_DATA_LANE 4'h8

`define BIT_WIDTH_LOW 0
`define BIT_HOST_ROLE 1
`define BIT_ARB_ENABLE 2
`define BIT_RESERVED3 3
`define BIT_PCI_CLOCK 4
`define BIT_DRIVE_LOW 5
`define BIT_WIDTH_HIGH 7
`define BIT_DRIVE_HIGH 9

`define STRAP_WIDTH 21
`define STRAP_DEFAULT 21'h1FFFFF

`define WIDTH_16 2'h0
`define WIDTH_8 2'h1
`define WIDTH_RSVD 2'h2
`define WIDTH_32 2'h3

`define DRIVE_RSVD 2'h0
`define DRIVE_MEDIUM 2'h1
`define DRIVE_LOW 2'h2
`define DRIVE_HIGH 2'h3

`define WOVR_ENABLE_BIT 2
`define FILLER_PATTERN 32'hA5A5A5A5

`endif

/* verification/boot_strap_config_capture_tb.sv */
// Self-checking bench for the strap capture block.
module boot_strap_config_capture_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Reset starts high so that the first assignment of zero makes a real falling edge.
  logic clk = 0, reset_n = 1, act = 0, wr = 0, we = 0, cyc = 0, stb = 0, ack, p66, arb, host, ok;
  logic [3:0] adr = 4'h0;
  logic [20:0] strapSet = 21'h1FFFFF, addrPins;
  logic [31:0] wdat = 0, core = 0, flash = 0, dPins, datO, pOut, pOe_n, rData, rd;
  logic [1:0] drv, fw;
  int errors = 0, checks_done = 0;
  // Half period of 25 ns gives the 20 MHz clock.
  always #25 clk = ~clk;
  boot_strap_config_capture dut_u (.clk(clk), .reset_n(reset_n), .expansionAddressPins(addrPins),
    .coreWriteData(core), .expansionDataPinsIn(dPins), .accessActive(act), .accessWrite(wr),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(datO), .wb_ack_o(ack), .expansionDataPinsOut(pOut),
    .expansionDataPinsOe_n(pOe_n), .readData(rData), .busDriveStrength(drv), .pciClockIs66(p66),
    .hostBusArbiterEnable(arb), .pciHostRole(host), .flashWidth(fw), .strapsValid(ok));
  strap_board board_u (.strapSet(strapSet), .flashWord(flash), .pinsOut(pOut), .pinsOe_n(pOe_n),
    .addrPins(addrPins), .dataPins(dPins));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task finish_test;
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One classic cycle; the answer is taken at the edge that shows ack.
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    rd = datO;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin errors++; finish_test; end
    @(posedge clk);
  endtask
  // Every reset draws new straps, with all drive and width codes forced in turn.
  initial begin
    logic [20:0] s;
    logic [31:0] m, r;
    logic [1:0] w;
    int n;
    void'($urandom(15));
    for (int i = 0; i < 8; i++) begin
      s = 21'($urandom());
      {s[9], s[5], s[7], s[0]} = {i[1:0], i[1:0]};
      w = ~i[1:0];
      strapSet <= s;
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      chk("reset config", 7'h7F, {drv, p66, arb, host, fw});
      reset_n <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (ok !== 1'b1 && n < 10);
      if (n >= 10) begin errors++; finish_test; end
      chk("config drive", {s[9], s[5]}, drv);
      chk("config pci", {s[4], s[2], s[1]}, {p66, arb, host});
      chk("config width", {s[7], s[0]}, fw);
      strapSet <= ~s;
      wb(1'b0, 4'h0, 0);
      chk("config reg", s | 21'h8, rd);
      wb(1'b0, 4'hC, 0);
      chk("unmapped", 0, rd);
      chk("held drive", {s[9], s[5], s[4]}, {drv, p66});
      wb(1'b1, 4'h4, {29'h1, w});
      repeat (2) @(posedge clk);
      chk("override width", w, fw);
      m = (w == 2'h1) ? 32'hFF : (w == 2'h0) ? 32'hFFFF : 32'hFFFFFFFF;
      r = $urandom();
      {act, wr, core} <= {2'b11, r};
      repeat (2) @(posedge clk);
      chk("write lanes", (r & m) | (32'hA5A5A5A5 & ~m), pOut);
      r = $urandom();
      {wr, flash} <= {1'b0, r};
      repeat (5) @(posedge clk);
      chk("read data", r & m, rData);
      act <= 1'b0;
      wb(1'b1, 4'h4, 0);
      repeat (2) @(posedge clk);
      chk("strapped width", {s[7], s[0]}, fw);
    end
    finish_test;
  end
endmodule

/* verification/strap_board.sv */
// Board strap resistors and boot flash on the expansion bus.
module strap_board (
  input wire [20:0] strapSet, // Strap pattern chosen by the bench.
  input wire [31:0] flashWord, // Word the flash answers with.
  input wire [31:0] pinsOut, // Level the device drives.
  input wire [31:0] pinsOe_n, // Low where the device drives.
  output logic [20:0] addrPins, // Strapped address pins.
  output logic [31:0] dataPins // Resolved data line levels.
);
  // Bit 3 stays high because the board never pulls it down.
  assign addrPins = strapSet | 21'h000008;
  // The flash drives every line the device has released.
  assign dataPins = (pinsOut & ~pinsOe_n) | (flashWord & pinsOe_n);
endmodule

/* verification/strap_props.sv */
// Port assertions and covers for the strap capture block.
module strap_props #(parameter DATA_WIDTH = 32) (
  input wire clk, input wire reset_n, input wire [20:0] expansionAddressPins,
  input wire accessActive, input wire accessWrite, input wire wb_ack_o,
  input wire [DATA_WIDTH-1:0] expansionDataPinsOe_n, input wire [1:0] busDriveStrength,
  input wire pciClockIs66, input wire hostBusArbiterEnable, input wire pciHostRole,
  input wire [1:0] flashWidth, input wire strapsValid);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  drive_decode_a: assert property ($rose(strapsValid) |-> busDriveStrength ==
    {$past(expansionAddressPins[9], 2), $past(expansionAddressPins[5], 2)}) else $error("drive");
  pci_mode_a: assert property ($rose(strapsValid) |-> pciClockIs66 ==
    $past(expansionAddressPins[4], 2) && hostBusArbiterEnable == $past(expansionAddressPins[2], 2)
    && pciHostRole == $past(expansionAddressPins[1], 2)) else $error("pci mode");
  flash_width_a: assert property ($rose(strapsValid) |-> flashWidth ==
    {$past(expansionAddressPins[7], 2), $past(expansionAddressPins[0], 2)}) else $error("width");
  write_drive_a: assert property (accessActive && accessWrite |=>
    expansionDataPinsOe_n == '0) else $error("write lanes not driven");
  read_release_a: assert property (!(accessActive && accessWrite) |=>
    &expansionDataPinsOe_n) else $error("lanes not released");
  strap_hold_a: assert property (strapsValid && $past(strapsValid) |-> $stable({pciClockIs66,
    busDriveStrength, hostBusArbiterEnable, pciHostRole})) else $error("config moved");
  reset_default_a: assert property (disable iff (1'b0) !reset_n |-> flashWidth == 2'h3)
    else $error("reset width");
  valid_release_a: assert property ($rose(reset_n) |-> !strapsValid [*4] ##1 strapsValid)
    else $error("capture timing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  cover property ($rose(strapsValid));
  cover property (accessActive && accessWrite && flashWidth == 2'h1);
  cover property (accessActive && !accessWrite && flashWidth == 2'h0);
endmodule
bind boot_strap_config_capture strap_props #(.DATA_WIDTH(DATA_WIDTH)) props_u (.clk(clk),
  .reset_n(reset_n), .expansionAddressPins(expansionAddressPins), .accessActive(accessActive),
  .accessWrite(accessWrite), .wb_ack_o(wb_ack_o), .expansionDataPinsOe_n(expansionDataPinsOe_n),
  .busDriveStrength(busDriveStrength), .pciClockIs66(pciClockIs66), .pciHostRole(pciHostRole),
  .hostBusArbiterEnable(hostBusArbiterEnable), .flashWidth(flashWidth), .strapsValid(strapsValid));
